// ---- pkg/t1ca_cfg.svh ----
// Register map, field positions, reset values and frame geometry
`ifndef T1CA_CFG_SVH
`define T1CA_CFG_SVH
`define T1CA_IDX_CTRL 8'h1E
`define T1CA_IDX_MON 8'h1F
`define T1CA_ADDR_W 8
`define T1CA_ADDR_LSB 2
`define T1CA_CTRL_RST 8'h00
`define T1CA_MON_RST 8'h00
`define T1CA_BIT_CRC 7
`define T1CA_BIT_RXALN 6
`define T1CA_BIT_TXALN 5
`define T1CA_CHAN_MSB 4
`define T1CA_CHAN_LSB 0
`define T1CA_SLOTS 24
`define T1CA_SLOT_BITS 8
`define T1CA_LAST_BIT 3'h7
`define T1CA_LAST_SLOT 5'h17
`define T1CA_RESP_OK 2'h0
`define T1CA_RESP_ERR 2'h2
`endif

// ---- pkg/t1ca_pkg.sv ----
// Types shared by the control and monitor modules
package t1ca_pkg;
    typedef logic [7:0] t1ca_byte_t;
    typedef logic [4:0] t1ca_chan_t;
    typedef logic [1:0] t1ca_resp_t;
    typedef enum logic [0:0] {
        MON_WAIT_FRAME,
        MON_IN_FRAME
    } t1ca_mon_state_t;
endpackage

// ---- rtl/t1ca_rx_monitor.sv ----
// Receive timeslot monitor: captures one selected timeslot per frame
`timescale 1ns/10ps
`default_nettype none
`include "t1ca_cfg.svh"
module t1ca_rx_monitor #(
    parameter int SLOT_BITS = `T1CA_SLOT_BITS
) (
    input wire logic clk, // System clock
    input wire logic arst_n, // Async reset, active low
    input wire logic ce, // Clock enable
    input wire logic bit_en, // Received bit strobe
    input wire logic bit_val, // Received bit value
    input wire logic frame_start, // Marks framing bit
    input wire t1ca_pkg::t1ca_chan_t chan_sel, // Selected timeslot
    output t1ca_pkg::t1ca_byte_t mon_byte, // Last complete byte
    output logic mon_update // Pulse on refresh
);
    t1ca_pkg::t1ca_mon_state_t state;
    t1ca_pkg::t1ca_chan_t slot;
    logic [2:0] bidx;
    t1ca_pkg::t1ca_byte_t shift;
    wire selected = (slot == chan_sel);
    wire step = ce & bit_en & (state == t1ca_pkg::MON_IN_FRAME) & ~frame_start;
    wire last_bit = (bidx == 3'(SLOT_BITS - 1));
    // First bit lands in the MSB after eight shifts
    wire [7:0] next_shift = {shift[6:0], bit_val};

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= t1ca_pkg::MON_WAIT_FRAME;
            slot <= 5'h00;
            bidx <= 3'h0;
        end else if (ce & bit_en & frame_start) begin
            state <= t1ca_pkg::MON_IN_FRAME;
            slot <= 5'h00;
            bidx <= 3'h0;
        end else if (step) begin
            bidx <= last_bit ? 3'h0 : bidx + 3'h1;
            if (last_bit) begin
                slot <= slot + 5'h01;
                if (slot == `T1CA_LAST_SLOT) begin
                    state <= t1ca_pkg::MON_WAIT_FRAME;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            shift <= `T1CA_MON_RST;
        end else if (step & selected) begin
            shift <= next_shift;
        end
    end

    // Load only on the last bit so a read never sees a half byte
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mon_byte <= `T1CA_MON_RST;
            mon_update <= 1'b0;
        end else if (ce) begin
            mon_update <= step & selected & last_bit;
            if (step & selected & last_bit) begin
                mon_byte <= next_shift;
            end
        end
    end
endmodule
`default_nettype wire

// ---- rtl/t1ca_top.sv ----
// CRC variant, elastic store align commands and receive timeslot monitor registers
//
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none
`include "t1ca_cfg.svh"
// Summary of operation
// - Variant bit low selects standard CRC6, high selects the Japanese CRC6.
// - Receive align rising edge requests half-frame pointer spacing unless already wider.
// - Transmit align rising edge requests half-frame pointer spacing unless already wider.
// - Align bits act on rising edge only; software clears and sets again.
// - Five-bit field in bits 4..0 selects the monitored received timeslot.
// - Selected timeslot appears read-only at index 1F, first bit in bit 7.
module t1ca_top (
    input wire logic SYS_CLK, // 20 MHz system clock
    input wire logic ARST_N, // Async reset, active low
    input wire logic CE, // Clock enable, freezes state when low
    input wire logic [7:0] S_AXI_AWADDR, // Write address
    input wire logic S_AXI_AWVALID, // Write address valid
    output logic S_AXI_AWREADY, // Write address ready
    input wire logic [31:0] S_AXI_WDATA, // Write data
    input wire logic [3:0] S_AXI_WSTRB, // Write strobes
    input wire logic S_AXI_WVALID, // Write data valid
    output logic S_AXI_WREADY, // Write data ready
    output logic [1:0] S_AXI_BRESP, // Write response
    output logic S_AXI_BVALID, // Write response valid
    input wire logic S_AXI_BREADY, // Write response ready
    input wire logic [7:0] S_AXI_ARADDR, // Read address
    input wire logic S_AXI_ARVALID, // Read address valid
    output logic S_AXI_ARREADY, // Read address ready
    output logic [31:0] S_AXI_RDATA, // Read data
    output logic [1:0] S_AXI_RRESP, // Read response
    output logic S_AXI_RVALID, // Read data valid
    input wire logic S_AXI_RREADY, // Read data ready
    input wire logic RX_BIT_EN, // Received bit strobe
    input wire logic RX_BIT, // Received bit value
    input wire logic RX_FRAME_START, // Framing bit marker
    input wire logic RX_STORE_HALF_APART, // Receive pointers already over half frame
    input wire logic TX_STORE_HALF_APART, // Transmit pointers already over half frame
    output logic CRC_VARIANT_SELECT, // High selects Japanese CRC6
    output logic RX_STORE_ALIGN, // Receive store align pulse
    output logic TX_STORE_ALIGN, // Transmit store align pulse
    output logic RX_MON_UPDATE // Pulse when monitor byte refreshed
);
    localparam logic [7:0] ADDR_CTRL = 8'(`T1CA_IDX_CTRL << `T1CA_ADDR_LSB);
    localparam logic [7:0] ADDR_MON = 8'(`T1CA_IDX_MON << `T1CA_ADDR_LSB);

    t1ca_pkg::t1ca_byte_t ctrl;
    t1ca_pkg::t1ca_byte_t mon_byte;
    logic [7:0] aw_addr;
    logic [7:0] w_data;
    logic w_lane0;
    logic aw_held;
    logic w_held;
    logic rx_aln_prev;
    logic tx_aln_prev;
    logic [1:0] half_meta;
    logic [1:0] half_sync;

    // Write channel decode
    wire aw_take = S_AXI_AWVALID & S_AXI_AWREADY;
    wire w_take = S_AXI_WVALID & S_AXI_WREADY;
    wire do_write = CE & aw_held & w_held & ~S_AXI_BVALID;
    wire wr_ctrl = (aw_addr == ADDR_CTRL);
    wire wr_mon = (aw_addr == ADDR_MON);
    wire wr_ok = wr_ctrl;
    wire ctrl_we = do_write & wr_ctrl & w_lane0;

    assign S_AXI_AWREADY = CE & ~aw_held & ~S_AXI_BVALID;
    assign S_AXI_WREADY = CE & ~w_held & ~S_AXI_BVALID;

    // Read channel decode
    wire ar_take = S_AXI_ARVALID & S_AXI_ARREADY;
    wire rd_ctrl = (S_AXI_ARADDR == ADDR_CTRL);
    wire rd_mon = (S_AXI_ARADDR == ADDR_MON);
    wire [7:0] rd_byte = rd_ctrl ? ctrl : (rd_mon ? mon_byte : 8'h00);
    wire [1:0] rd_resp = (rd_ctrl | rd_mon) ? `T1CA_RESP_OK : `T1CA_RESP_ERR;

    assign S_AXI_ARREADY = CE & ~S_AXI_RVALID;

    // Field views of the control register
    wire rx_aln = ctrl[`T1CA_BIT_RXALN];
    wire tx_aln = ctrl[`T1CA_BIT_TXALN];
    wire t1ca_pkg::t1ca_chan_t chan_sel = ctrl[`T1CA_CHAN_MSB:`T1CA_CHAN_LSB];
    wire rx_aln_rise = rx_aln & ~rx_aln_prev;
    wire tx_aln_rise = tx_aln & ~tx_aln_prev;
    // Spacing status is two cycles old when a pulse is judged
    wire rx_half = half_sync[0];
    wire tx_half = half_sync[1];

    // Combinational pulses; hold-off when the store is already spread wide enough
    assign RX_STORE_ALIGN = CE & rx_aln_rise & ~rx_half;
    assign TX_STORE_ALIGN = CE & tx_aln_rise & ~tx_half;
    assign CRC_VARIANT_SELECT = ctrl[`T1CA_BIT_CRC];

    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            aw_held <= 1'b0;
            aw_addr <= 8'h00;
        end else if (CE) begin
            if (aw_take) begin
                aw_held <= 1'b1;
                aw_addr <= S_AXI_AWADDR;
            end else if (do_write) begin
                aw_held <= 1'b0;
            end
        end
    end

    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            w_held <= 1'b0;
            w_data <= 8'h00;
            w_lane0 <= 1'b0;
        end else if (CE) begin
            if (w_take) begin
                w_held <= 1'b1;
                w_data <= S_AXI_WDATA[7:0];
                w_lane0 <= S_AXI_WSTRB[0];
            end else if (do_write) begin
                w_held <= 1'b0;
            end
        end
    end

    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= `T1CA_RESP_OK;
        end else if (CE) begin
            if (do_write) begin
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP <= wr_ok ? `T1CA_RESP_OK : `T1CA_RESP_ERR;
            end else if (S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
            end
        end
    end

    // Monitor index is read-only; a write there is answered with an error
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ctrl <= `T1CA_CTRL_RST;
        end else if (ctrl_we & ~wr_mon) begin
            ctrl <= w_data;
        end
    end

    // Spacing flags come from the store's own clock, so two stages before use
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            half_meta <= 2'b00;
            half_sync <= 2'b00;
        end else if (CE) begin
            half_meta <= {TX_STORE_HALF_APART, RX_STORE_HALF_APART};
            half_sync <= half_meta;
        end
    end

    // Edge memory tracks the stored bit, so holding it high never repeats
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rx_aln_prev <= 1'b0;
            tx_aln_prev <= 1'b0;
        end else if (CE) begin
            rx_aln_prev <= rx_aln;
            tx_aln_prev <= tx_aln;
        end
    end

    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA <= 32'h0000_0000;
            S_AXI_RRESP <= `T1CA_RESP_OK;
        end else if (CE) begin
            if (ar_take) begin
                S_AXI_RVALID <= 1'b1;
                S_AXI_RDATA <= {24'h00_0000, rd_byte};
                S_AXI_RRESP <= rd_resp;
            end else if (S_AXI_RREADY) begin
                S_AXI_RVALID <= 1'b0;
            end
        end
    end

    t1ca_rx_monitor #(
        .SLOT_BITS(`T1CA_SLOT_BITS)
    ) u_mon (
        .clk(SYS_CLK),
        .arst_n(ARST_N),
        .ce(CE),
        .bit_en(RX_BIT_EN),
        .bit_val(RX_BIT),
        .frame_start(RX_FRAME_START),
        .chan_sel(chan_sel),
        .mon_byte(mon_byte),
        .mon_update(RX_MON_UPDATE)
    );
endmodule
`default_nettype wire

// ---- test/t1ca_chk_sva.sv ----
// Concurrent checks on the control and receive monitor register block
`timescale 1ns/10ps
`default_nettype none
module t1ca_chk (
    input wire logic SYS_CLK, // Clock
    input wire logic ARST_N, // Reset
    input wire logic CE, // Enable
    input wire logic S_AXI_AWVALID, // Bus
    input wire logic S_AXI_AWREADY, // Bus
    input wire logic S_AXI_WVALID, // Bus
    input wire logic S_AXI_WREADY, // Bus
    input wire logic S_AXI_BVALID, // Bus
    input wire logic S_AXI_ARVALID, // Bus
    input wire logic S_AXI_ARREADY, // Bus
    input wire logic [31:0] S_AXI_RDATA, // Bus
    input wire logic S_AXI_RVALID, // Bus
    input wire logic S_AXI_RREADY, // Bus
    input wire logic RX_BIT_EN, // Strobe
    input wire logic RX_STORE_HALF_APART, // Spacing
    input wire logic TX_STORE_HALF_APART, // Spacing
    input wire logic CRC_VARIANT_SELECT, // Variant
    input wire logic RX_STORE_ALIGN, // Pulse
    input wire logic TX_STORE_ALIGN, // Pulse
    input wire logic RX_MON_UPDATE // Pulse
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!ARST_N);
    sequence s_wtake;
        S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
    endsequence
    sequence s_rtake;
        S_AXI_ARVALID && S_AXI_ARREADY;
    endsequence
    property p_wr;
        s_wtake ##1 CE |=> S_AXI_BVALID;
    endproperty
    a_wr: assert property (p_wr) else $error("write response late");
    property p_crc;
        $changed(CRC_VARIANT_SELECT) |-> $rose(S_AXI_BVALID);
    endproperty
    a_crc: assert property (p_crc) else $error("variant moved without write");
    property p_rxal;
        RX_STORE_ALIGN |-> !$past(RX_STORE_HALF_APART, 2) ##1 !RX_STORE_ALIGN;
    endproperty
    a_rxal: assert property (p_rxal) else $error("bad rx align pulse");
    property p_txal;
        TX_STORE_ALIGN |-> !$past(TX_STORE_HALF_APART, 2) ##1 !TX_STORE_ALIGN;
    endproperty
    a_txal: assert property (p_txal) else $error("bad tx align pulse");
    property p_rd;
        s_rtake |=> S_AXI_RVALID && S_AXI_RDATA[31:8] == 24'h000000;
    endproperty
    a_rd: assert property (p_rd) else $error("read answer wrong");
    property p_rdone;
        S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID;
    endproperty
    a_rdone: assert property (p_rdone) else $error("read answer stuck");
    property p_upd;
        RX_MON_UPDATE |-> $past(RX_BIT_EN) ##1 !RX_MON_UPDATE;
    endproperty
    a_upd: assert property (p_upd) else $error("monitor refresh off strobe");
endmodule
bind t1ca_top t1ca_chk u_chk (.*);
`default_nettype wire

// ---- test/tb.sv ----
// Self-checking bench for the control and receive monitor registers
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic SYS_CLK = 0, ARST_N = 0, CE = 1;
    logic [7:0] S_AXI_AWADDR = 0, S_AXI_ARADDR = 0;
    logic [31:0] S_AXI_WDATA = 0, S_AXI_RDATA;
    logic [3:0] S_AXI_WSTRB = 4'hF;
    logic S_AXI_AWVALID = 0, S_AXI_WVALID = 0, S_AXI_BREADY = 0;
    logic S_AXI_ARVALID = 0, S_AXI_RREADY = 0, RX_BIT_EN = 0, RX_BIT = 0;
    logic RX_FRAME_START = 0, RX_STORE_HALF_APART = 0, TX_STORE_HALF_APART = 0;
    logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
    logic [1:0] S_AXI_BRESP, S_AXI_RRESP, r;
    logic CRC_VARIANT_SELECT, RX_STORE_ALIGN, TX_STORE_ALIGN, RX_MON_UPDATE;
    logic [31:0] d;
    logic [7:0] m;
    logic [4:0] sel [3] = '{5'h00, 5'h0E, 5'h17};
    int n_mismatch = 0, checks = 0, n_rx = 0, n_tx = 0, n_up = 0;
    t1ca_top uut (.*);
    always #25 SYS_CLK = ~SYS_CLK;
    always @(posedge SYS_CLK) begin
        n_rx <= n_rx + RX_STORE_ALIGN;
        n_tx <= n_tx + TX_STORE_ALIGN;
        n_up <= n_up + RX_MON_UPDATE;
    end
    function automatic logic [7:0] pat(input int s);
        return 8'(s * 11 + 53);
    endfunction
    task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        checks++;
        if (s !== e) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask
    // Readies are sampled mid-cycle; they only change at edges
    task wr(input logic [7:0] a, input logic [7:0] v);
        logic ka, kw, kb;
        kb = 0;
        @(posedge SYS_CLK);
        S_AXI_AWADDR <= a;
        S_AXI_WDATA <= {24'h000000, v};
        S_AXI_AWVALID <= 1;
        S_AXI_WVALID <= 1;
        S_AXI_BREADY <= 1;
        while (!kb) begin
            @(negedge SYS_CLK);
            ka = S_AXI_AWREADY;
            kw = S_AXI_WREADY;
            kb = S_AXI_BVALID;
            r = S_AXI_BRESP;
            @(posedge SYS_CLK);
            if (ka) S_AXI_AWVALID <= 0;
            if (kw) S_AXI_WVALID <= 0;
        end
        S_AXI_BREADY <= 0;
    endtask
    task rc(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
        logic ka, kr;
        kr = 0;
        @(posedge SYS_CLK);
        S_AXI_ARADDR <= a;
        S_AXI_ARVALID <= 1;
        S_AXI_RREADY <= 1;
        while (!kr) begin
            @(negedge SYS_CLK);
            ka = S_AXI_ARREADY;
            kr = S_AXI_RVALID;
            d = S_AXI_RDATA;
            r = S_AXI_RRESP;
            @(posedge SYS_CLK);
            if (ka) S_AXI_ARVALID <= 0;
        end
        S_AXI_RREADY <= 0;
        chk("rdata", {24'h000000, e}, d);
        chk("rresp", {30'h0, er}, {30'h0, r});
    endtask
    // Framing bit then 24 slots, first bit of each slot sent first
    task frame;
        logic [7:0] b;
        for (int i = -1; i < 192; i++) begin
            b = pat(i / 8);
            @(posedge SYS_CLK);
            RX_BIT_EN <= 1;
            RX_FRAME_START <= (i < 0);
            RX_BIT <= b[7 - (i & 7)];
            @(posedge SYS_CLK);
            RX_BIT_EN <= 0;
        end
    endtask
    task tally_and_finish;
        $display("Checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        #1000000;
        n_mismatch++;
        tally_and_finish;
    end
    initial begin
        repeat (3) @(posedge SYS_CLK);
        ARST_N <= 1;
        rc(8'h78, 8'h00, 2'h0);
        rc(8'h7C, 8'h00, 2'h0);
        rc(8'h40, 8'h00, 2'h2);
        wr(8'h7C, 8'hFF);
        chk("bresp", 32'h2, {30'h0, r});
        rc(8'h7C, 8'h00, 2'h0);
        wr(8'h78, 8'h80);
        chk("bresp", 32'h0, {30'h0, r});
        chk("crc", 32'h1, CRC_VARIANT_SELECT);
        rc(8'h78, 8'h80, 2'h0);
        wr(8'h78, 8'h00);
        chk("crc", 32'h0, CRC_VARIANT_SELECT);
        // Lane zero masked off: answered OK, register untouched
        S_AXI_WSTRB <= 4'hE;
        wr(8'h78, 8'h80);
        S_AXI_WSTRB <= 4'hF;
        chk("bresp", 32'h0, {30'h0, r});
        chk("crc", 32'h0, CRC_VARIANT_SELECT);
        $display("Test access and variant done");
        for (int k = 0; k < 2; k++) begin
            m = 8'h40 >> k;
            wr(8'h78, m);
            wr(8'h78, m);
            wr(8'h78, 8'h00);
            RX_STORE_HALF_APART <= 1;
            TX_STORE_HALF_APART <= 1;
            wr(8'h78, m);
            RX_STORE_HALF_APART <= 0;
            TX_STORE_HALF_APART <= 0;
            wr(8'h78, 8'h00);
        end
        chk("rx_align", 32'h1, n_rx);
        chk("tx_align", 32'h1, n_tx);
        $display("Test align done");
        foreach (sel[j]) begin
            wr(8'h78, {3'b000, sel[j]});
            frame();
            rc(8'h7C, pat(sel[j]), 2'h0);
        end
        // Select beyond the last slot must leave the byte alone
        wr(8'h78, 8'h18);
        frame();
        rc(8'h7C, pat(23), 2'h0);
        chk("updates", 32'h3, n_up);
        $display("Test monitor done");
        tally_and_finish;
    end
endmodule
`default_nettype wire
